// >>> cts_pkg.sv
package cts_pkg;

    // Camera trigger behaviour chosen by the operator.
    typedef enum logic [1:0] {
        CTS_TRIG_MANUAL,
        CTS_TRIG_INTERVAL,
        CTS_TRIG_EDGE,
        CTS_TRIG_LEVEL
    } cts_trig_mode_t;

    // Where the sync pulse is taken from.
    typedef enum logic [2:0] {
        CTS_SYNC_INTERNAL,
        CTS_SYNC_GENERAL,
        CTS_SYNC_VIDEO,
        CTS_SYNC_HEAD,
        CTS_SYNC_DISABLED
    } cts_sync_src_t;

    // Per-axis recording behaviour.
    typedef enum logic [1:0] {
        CTS_AXIS_RECORD,
        CTS_AXIS_LIVE,
        CTS_AXIS_IGNORE,
        CTS_AXIS_UNUSED
    } cts_axis_mode_t;

    localparam int CTS_NUM_AXES = 4;
    localparam int CTS_CLK_HZ = 125_000_000;
    localparam int CTS_SEC_CYCLES = CTS_CLK_HZ;
    localparam logic [7:0] CTS_EDGE_PULSE_RST = 8'h10;
    localparam logic [7:0] CTS_SYNC_TIMEOUT_RST = 8'h05;
    localparam logic [7:0] CTS_BLOOP_PULSE_CYCLES = 8'h10;
    localparam logic [7:0] CTS_ACCEL_FRACTION_RST = 8'h19;
    localparam logic [7:0] CTS_DECEL_FRACTION_RST = 8'h19;
    localparam logic [31:0] CTS_STORE_CYCLES_RST = 32'h0000_0000;

    // Operator and configuration inputs grouped together.
    typedef struct packed {
        cts_trig_mode_t trig_mode;
        cts_sync_src_t sync_source_select;
        logic [7:0] sync_timeout_sec;
        logic [7:0] edge_pulse_cycles;
        logic [7:0] accel_fraction;
        logic [7:0] decel_fraction;
    } cts_cfg_t;

    // Status shown to the operator panel.
    typedef struct packed {
        logic ready_to_goto;
        logic performing_goto;
        logic ready_to_shoot;
        logic awaiting_sync;
        logic shooting;
        logic recording;
        logic sync_fail_indication;
    } cts_status_t;

endpackage : cts_pkg

// >>> cts_sequencer.sv
module cts_sequencer (
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Operator buttons, one-cycle pulses except the camera button and the play mode level.
    input wire logic select_i,
    input wire logic back_i,
    input wire logic play_mode_i,
    input wire logic camera_button_i,
    // Configuration.
    input wire cts_pkg::cts_cfg_t cfg_i,
    input wire cts_pkg::cts_axis_mode_t [cts_pkg::CTS_NUM_AXES-1:0] axis_mode_i,
    input wire logic [31:0] store_cycles_i,
    input wire logic [31:0] move_cycles_i,
    // Motion feedback.
    input wire logic at_start_i,
    input wire logic move_done_i,
    input wire logic frame_start_i,
    // Sync inputs.
    input wire logic general_input_one_i,
    input wire logic head_sync_i,
    // Camera outputs.
    output logic camera_trigger_o,
    output logic bloop_focus_o,
    // Motion outputs.
    output logic goto_start_o,
    output logic move_run_o,
    output logic move_stop_o,
    output logic [15:0] speed_o,
    output logic record_commit_o,
    output logic record_discard_o,
    output logic [31:0] time_left_o,
    output logic [cts_pkg::CTS_NUM_AXES-1:0] axis_record_o,
    output logic [cts_pkg::CTS_NUM_AXES-1:0] axis_control_o,
    // Panel status.
    output cts_pkg::cts_status_t status_o
);

    typedef enum logic [2:0] {
        CTS_IDLE, CTS_GOTO, CTS_READY, CTS_WAIT_PLAY, CTS_SHOOT, CTS_WAIT_REC, CTS_REC
    } cts_state_t;

    cts_state_t state;
    cts_state_t next_state;
    logic sync_prev;
    logic [31:0] sec_cnt;
    logic [7:0] sec_left;
    logic [7:0] edge_cnt;
    logic [7:0] bloop_cnt;
    logic [31:0] move_cnt;
    logic sync_fail;
    logic play_trig;

    // Only general and head sources gate; internal and video act like disabled.
    wire sync_gated = cfg_i.sync_source_select == cts_pkg::CTS_SYNC_GENERAL
        || cfg_i.sync_source_select == cts_pkg::CTS_SYNC_HEAD;
    wire sync_level = (cfg_i.sync_source_select == cts_pkg::CTS_SYNC_HEAD)
        ? head_sync_i : general_input_one_i;
    wire sync_rise = sync_level & ~sync_prev;
    wire waiting = state == CTS_WAIT_PLAY || state == CTS_WAIT_REC;
    wire timeout = waiting && sec_left == 8'h00;
    wire shoot_begin = next_state == CTS_SHOOT && state != CTS_SHOOT;
    wire shoot_end = state == CTS_SHOOT && next_state != CTS_SHOOT;
    wire sel_shoot = state == CTS_READY && select_i;
    wire is_edge = cfg_i.trig_mode == cts_pkg::CTS_TRIG_EDGE;
    wire is_level = cfg_i.trig_mode == cts_pkg::CTS_TRIG_LEVEL;
    wire is_interval = cfg_i.trig_mode == cts_pkg::CTS_TRIG_INTERVAL;
    wire is_manual = cfg_i.trig_mode == cts_pkg::CTS_TRIG_MANUAL;
    // A start select in the ready state, unless back overrides it.
    wire start_cmd = sel_shoot && !back_i;
    // Edge mode fires on the start command and again at the shoot end, so sync arrival adds no pulse.
    wire edge_fire = is_edge && (start_cmd || shoot_end);
    wire [31:0] accel_len = frac_of(move_cycles_i, cfg_i.accel_fraction);
    wire [31:0] decel_len = frac_of(move_cycles_i, cfg_i.decel_fraction);

    // Percentage of a cycle count, rounded down.
    function automatic logic [31:0] frac_of(input logic [31:0] total, input logic [7:0] pct);
        logic [39:0] prod;
        prod = total * pct;
        return 32'(prod / 40'd100);
    endfunction : frac_of

    // Linear ramp scaled to full speed 16'hffff.
    function automatic logic [15:0] ramp(input logic [31:0] pos, input logic [31:0] len);
        logic [47:0] prod;
        prod = {pos, 16'h0000};
        // A position at or past the ramp length would overflow 16 bits, so it saturates.
        return (len == 32'h0 || pos >= len) ? 16'hffff : 16'(prod / {16'h0000, len});
    endfunction : ramp

    always_comb
    begin
        next_state = state;
        unique case (state)
            CTS_IDLE:
                if (select_i && play_mode_i)
                    next_state = CTS_GOTO;
                else if (select_i)
                    next_state = sync_gated ? CTS_WAIT_REC : CTS_REC;
            CTS_GOTO:
                if (back_i)
                    next_state = CTS_IDLE;
                else if (at_start_i)
                    next_state = CTS_READY;
            CTS_READY:
                if (back_i)
                    next_state = CTS_IDLE;
                else if (select_i)
                    next_state = sync_gated ? CTS_WAIT_PLAY : CTS_SHOOT;
            CTS_WAIT_PLAY:
                if (back_i || timeout)
                    next_state = CTS_IDLE;
                else if (sync_rise)
                    next_state = CTS_SHOOT;
            CTS_SHOOT:
                if (back_i || move_done_i)
                    next_state = CTS_IDLE;
            CTS_WAIT_REC:
                if (back_i || timeout)
                    next_state = CTS_IDLE;
                else if (sync_rise)
                    next_state = CTS_REC;
            CTS_REC:
                if (back_i || select_i || time_left_o == 32'h0)
                    next_state = CTS_IDLE;
            default:
                next_state = CTS_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            state <= CTS_IDLE;
            sync_prev <= 1'b0;
            sync_fail <= 1'b0;
        end
        else
        begin
            state <= next_state;
            sync_prev <= sync_level;
            // A new start clears the old failure; a timeout sets it.
            sync_fail <= timeout | (sync_fail & ~select_i);
        end
    end

    // Seconds counter for the sync wait, reloaded on entry.
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i || !waiting)
        begin
            sec_cnt <= 32'h0;
            sec_left <= (!resetn_i) ? cts_pkg::CTS_SYNC_TIMEOUT_RST : cfg_i.sync_timeout_sec;
        end
        else if (sec_cnt == 32'(cts_pkg::CTS_SEC_CYCLES - 1))
        begin
            sec_cnt <= 32'h0;
            sec_left <= sec_left - 8'h01;
        end
        else
            sec_cnt <= sec_cnt + 32'h1;
    end

    // Pulse timers for edge trigger and bloop.
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            edge_cnt <= 8'h00;
            bloop_cnt <= 8'h00;
        end
        else
        begin
            // The fire cycle is the first cycle of the pulse, so the counter holds one less.
            if (edge_fire)
                edge_cnt <= (cfg_i.edge_pulse_cycles == 8'h00) ? 8'h00
                    : cfg_i.edge_pulse_cycles - 8'h01;
            else if (edge_cnt != 8'h00)
                edge_cnt <= edge_cnt - 8'h01;
            if (shoot_begin && !is_interval)
                bloop_cnt <= cts_pkg::CTS_BLOOP_PULSE_CYCLES;
            else if (bloop_cnt != 8'h00)
                bloop_cnt <= bloop_cnt - 8'h01;
        end
    end

    // Move position and remaining store time.
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i || state != CTS_SHOOT)
            move_cnt <= 32'h0;
        else
            move_cnt <= move_cnt + 32'h1;
        if (!resetn_i)
            time_left_o <= cts_pkg::CTS_STORE_CYCLES_RST;
        else if (state == CTS_REC && time_left_o != 32'h0)
            time_left_o <= time_left_o - 32'h1;
        else if (state == CTS_IDLE)
            time_left_o <= store_cycles_i;
    end

    // Fairing profile: ramp up, cruise, ramp down.
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i || state != CTS_SHOOT)
            speed_o <= 16'h0000;
        else if (move_cnt < accel_len)
            speed_o <= ramp(move_cnt, accel_len);
        else if (move_cnt + decel_len >= move_cycles_i)
            speed_o <= ramp(move_cycles_i - move_cnt, decel_len);
        else
            speed_o <= 16'hffff;
    end

    // Trigger source per mode; in edge and level modes the sync-gated start fires on the start select.
    always_comb
    begin
        play_trig = 1'b0;
        unique case (cfg_i.trig_mode)
            cts_pkg::CTS_TRIG_MANUAL:
                play_trig = camera_button_i;
            cts_pkg::CTS_TRIG_INTERVAL:
                play_trig = state == CTS_SHOOT && frame_start_i;
            cts_pkg::CTS_TRIG_EDGE:
                play_trig = edge_cnt != 8'h00 || edge_fire;
            cts_pkg::CTS_TRIG_LEVEL:
                play_trig = state == CTS_SHOOT || state == CTS_WAIT_PLAY
                    || start_cmd;
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            camera_trigger_o <= 1'b0;
            bloop_focus_o <= 1'b0;
        end
        else
        begin
            camera_trigger_o <= play_trig;
            bloop_focus_o <= is_interval ? play_trig
                : ((shoot_begin & ~is_manual) | (shoot_begin & is_manual)
                    | (bloop_cnt > 8'h01));
        end
    end

    // Axis recording and control per mode.
    always_comb
    begin
        for (int i = 0; i < cts_pkg::CTS_NUM_AXES; i++)
        begin
            axis_record_o[i] = state == CTS_REC && axis_mode_i[i] == cts_pkg::CTS_AXIS_RECORD;
            axis_control_o[i] = axis_mode_i[i] == cts_pkg::CTS_AXIS_LIVE
                || (state != CTS_SHOOT && axis_mode_i[i] == cts_pkg::CTS_AXIS_RECORD);
        end
    end

    assign goto_start_o = state == CTS_GOTO;
    assign move_run_o = state == CTS_SHOOT;
    assign move_stop_o = state == CTS_SHOOT && back_i;
    assign record_commit_o = state == CTS_REC && select_i && !back_i;
    assign record_discard_o = state == CTS_REC && back_i;
    assign status_o.ready_to_goto = state == CTS_IDLE && play_mode_i;
    assign status_o.performing_goto = state == CTS_GOTO;
    assign status_o.ready_to_shoot = state == CTS_READY;
    assign status_o.awaiting_sync = waiting;
    assign status_o.shooting = state == CTS_SHOOT;
    assign status_o.recording = state == CTS_REC;
    assign status_o.sync_fail_indication = sync_fail;

    nosync_start_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        sel_shoot && !back_i && !sync_gated |=> move_run_o)
        else $error("Start without sync did not run the move.");
    sync_hold_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        sel_shoot && !back_i && sync_gated |=> status_o.awaiting_sync && !move_run_o)
        else $error("Sync-gated start did not wait.");
    timeout_fail_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        timeout && !sync_rise |=> !move_run_o && status_o.sync_fail_indication)
        else $error("Sync timeout did not cancel and flag.");
    manual_trig_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        is_manual && $stable(cfg_i) |=> camera_trigger_o == $past(camera_button_i))
        else $error("Manual trigger does not follow the button.");
    level_trig_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        is_level && move_run_o && $past(move_run_o) |-> camera_trigger_o)
        else $error("Level trigger dropped during playback.");
    focus_mirror_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        is_interval && $past(is_interval) |-> bloop_focus_o == camera_trigger_o)
        else $error("Focus output differs from trigger.");
    back_stop_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        back_i && !status_o.recording |=> !move_run_o && !goto_start_o)
        else $error("Back did not stop playback.");
    rec_abort_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        record_discard_o |=> !status_o.recording && !record_commit_o)
        else $error("Back did not abort recording.");
    bloop_start_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        shoot_begin && !is_interval |=> bloop_focus_o)
        else $error("Bloop missing at move start.");

    shoot_cov: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
        status_o.ready_to_shoot ##1 move_run_o);
    sync_cov: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
        status_o.awaiting_sync ##1 move_run_o);
    fail_cov: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
        $rose(status_o.sync_fail_indication));
    commit_cov: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
        record_commit_o);

endmodule : cts_sequencer

// >>> cts_cam_model.sv
module cts_cam_model (
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Camera side.
    input wire logic camera_trigger_i,
    input wire logic [1:0] sync_line_i,
    input wire logic [7:0] start_delay_i,
    // Sync outputs, low while idle.
    output logic general_input_one_o,
    output logic head_sync_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic trig_q;
    logic [7:0] wait_cnt;
    logic [1:0] pulse_cnt;
    wire logic sync_now = pulse_cnt != 2'h0;
    // The camera sends no sync until a trigger has started it.
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            trig_q <= 1'b0;
            wait_cnt <= 8'h00;
            pulse_cnt <= 2'h0;
        end
        else
        begin
            trig_q <= camera_trigger_i;
            if (camera_trigger_i && !trig_q && sync_line_i != 2'h0)
                wait_cnt <= start_delay_i;
            else if (wait_cnt != 8'h00)
                wait_cnt <= wait_cnt - 8'h01;
            if (wait_cnt == 8'h01)
                pulse_cnt <= 2'h3;
            else if (sync_now)
                pulse_cnt <= pulse_cnt - 2'h1;
        end
    end
    // Each pulse rises from a low idle level.
    assign general_input_one_o = sync_now && sync_line_i == 2'h1;
    assign head_sync_o = sync_now && sync_line_i == 2'h2;
endmodule : cts_cam_model

// >>> cts_sequencer_tb_top.sv
module cts_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic select_i = 1'b0, back_i = 1'b0, move_done_i = 1'b0, frame_start_i = 1'b0;
    logic play_mode_i = 1'b1, camera_button_i = 1'b0, at_start_i = 1'b0;
    cts_pkg::cts_cfg_t cfg_i;
    cts_pkg::cts_axis_mode_t [cts_pkg::CTS_NUM_AXES-1:0] axis_mode_i;
    logic [31:0] store_cycles_i, move_cycles_i, time_left_o;
    logic [1:0] sync_line = 2'h0;
    logic general_input_one_i, head_sync_i, camera_trigger_o, bloop_focus_o;
    logic goto_start_o, move_run_o, move_stop_o, record_commit_o, record_discard_o;
    logic [15:0] speed_o;
    logic [3:0] axis_record_o, axis_control_o;
    cts_pkg::cts_status_t status_o;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    integer seed = 32'h6c55a306;
    logic [6:0] exp_q[$];
    logic [6:0] prev = 7'h00;
    logic [6:0] seen;
    logic [6:0] want;
    logic [7:0] sync_delay;
    logic [3:0] rec_mask, live_mask;

    initial forever #4 clk_sys_i = ~clk_sys_i;

    cts_sequencer dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .select_i(select_i),
        .back_i(back_i), .play_mode_i(play_mode_i), .camera_button_i(camera_button_i),
        .cfg_i(cfg_i), .axis_mode_i(axis_mode_i), .store_cycles_i(store_cycles_i),
        .move_cycles_i(move_cycles_i), .at_start_i(at_start_i), .move_done_i(move_done_i),
        .frame_start_i(frame_start_i), .general_input_one_i(general_input_one_i),
        .head_sync_i(head_sync_i), .camera_trigger_o(camera_trigger_o),
        .bloop_focus_o(bloop_focus_o), .goto_start_o(goto_start_o), .move_run_o(move_run_o),
        .move_stop_o(move_stop_o), .speed_o(speed_o), .record_commit_o(record_commit_o),
        .record_discard_o(record_discard_o), .time_left_o(time_left_o),
        .axis_record_o(axis_record_o), .axis_control_o(axis_control_o), .status_o(status_o));

    cts_cam_model cam (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .camera_trigger_i(camera_trigger_o), .sync_line_i(sync_line), .start_delay_i(sync_delay),
        .general_input_one_o(general_input_one_i), .head_sync_o(head_sync_i));

    task automatic check(input string name, input logic [31:0] got, input logic [31:0] want);
        checked++;
        if (got !== want)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, want, got);
        end
    endtask : check

    task automatic give_verdict();
        if (miscompares == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : tick

    // Pulses one of frame_start, move_done, back and select for a single cycle.
    task automatic press(input logic [3:0] k);
        @(posedge clk_sys_i);
        {frame_start_i, move_done_i, back_i, select_i} <= k;
        @(posedge clk_sys_i);
        {frame_start_i, move_done_i, back_i, select_i} <= 4'h0;
    endtask : press

    // A second select during the goto must be ignored; only the one after arrival shoots.
    task automatic play(input logic [6:0] first);
        #1;
        check("ready_goto", status_o.ready_to_goto, 1'b1);
        press(4'h1);
        press(4'h1);
        #1;
        check("goto", {goto_start_o, status_o.performing_goto}, 2'h3);
        tick(2);
        at_start_i <= 1'b1;
        tick(3);
        #1;
        check("ready_shoot", status_o.ready_to_shoot, 1'b1);
        exp_q.push_back(first);
        press(4'h1);
        at_start_i <= 1'b0;
    endtask : play

    // Event vector: trigger, bloop, run, recording, sync failed, commit, discard.
    always @(posedge clk_sys_i)
    begin
        seen = {camera_trigger_o, bloop_focus_o, move_run_o, status_o.recording,
            status_o.sync_fail_indication, record_commit_o, record_discard_o};
        cycles++;
        if (resetn_i && seen !== prev)
        begin
            want = exp_q.size() > 0 ? exp_q.pop_front() : 7'h7f;
            check("events", seen, want);
        end
        if (resetn_i && back_i && status_o.shooting)
            check("move_stop", move_stop_o, 1'b1);
        prev = seen;
        if (cycles == 3000)
        begin
            miscompares++;
            give_verdict();
        end
    end

    initial
    begin
        cfg_i = '0;
        cfg_i.trig_mode = cts_pkg::CTS_TRIG_LEVEL;
        cfg_i.sync_source_select = cts_pkg::CTS_SYNC_INTERNAL;
        cfg_i.sync_timeout_sec = 8'h05;
        // Kept under the camera's start delay so the start pulse ends before sync.
        cfg_i.edge_pulse_cycles = 8'h02 + 8'($unsigned($random(seed)) % 4);
        sync_delay = 8'h08 + 8'($unsigned($random(seed)) % 8);
        cfg_i.accel_fraction = cts_pkg::CTS_ACCEL_FRACTION_RST;
        cfg_i.decel_fraction = cts_pkg::CTS_DECEL_FRACTION_RST;
        for (int i = 0; i < cts_pkg::CTS_NUM_AXES; i++)
        begin
            axis_mode_i[i] = cts_pkg::cts_axis_mode_t'($unsigned($random(seed)) % 3);
            rec_mask[i] = axis_mode_i[i] == cts_pkg::CTS_AXIS_RECORD;
            live_mask[i] = axis_mode_i[i] == cts_pkg::CTS_AXIS_LIVE;
        end
        store_cycles_i = 32'h0000_1000 | 32'($unsigned($random(seed)) % 256);
        // Long enough that the cruise window always lies between the two fairings.
        move_cycles_i = 32'h0000_0100 + 32'($unsigned($random(seed)) % 64);
        tick(5);
        resetn_i <= 1'b1;
        tick(2);
        play(7'h70);
        exp_q.push_back(7'h50);
        tick(16);
        #1;
        check("accel", speed_o > 16'h0000 && speed_o < 16'hffff, 1'b1);
        tick(84);
        #1;
        check("cruise", speed_o, 16'hffff);
        check("shooting", status_o.shooting, 1'b1);
        check("axis_ctrl", axis_control_o, live_mask);
        tick(151);
        #1;
        check("decel", speed_o > 16'h0000 && speed_o < 16'hffff, 1'b1);
        exp_q.push_back(7'h40);
        exp_q.push_back(7'h00);
        press(4'h2);
        tick(5);
        #1;
        check("stopped", speed_o, 16'h0000);
        cfg_i.trig_mode <= cts_pkg::CTS_TRIG_EDGE;
        cfg_i.sync_source_select <= cts_pkg::CTS_SYNC_HEAD;
        sync_line <= 2'h2;
        tick(1);
        play(7'h40);
        #1;
        check("awaiting", status_o.awaiting_sync, 1'b1);
        exp_q.push_back(7'h00);
        exp_q.push_back(7'h30);
        exp_q.push_back(7'h10);
        tick(40);
        sync_line <= 2'h0;
        exp_q.push_back(7'h40);
        exp_q.push_back(7'h00);
        press(4'h2);
        tick(12);
        cfg_i.trig_mode <= cts_pkg::CTS_TRIG_INTERVAL;
        cfg_i.sync_source_select <= cts_pkg::CTS_SYNC_DISABLED;
        play_mode_i <= 1'b0;
        exp_q.push_back(7'h08);
        press(4'h1);
        tick(20);
        #1;
        check("time_left", time_left_o < store_cycles_i, 1'b1);
        check("axis_rec", axis_record_o, rec_mask);
        exp_q.push_back(7'h0a);
        exp_q.push_back(7'h00);
        press(4'h1);
        tick(3);
        exp_q.push_back(7'h08);
        exp_q.push_back(7'h09);
        exp_q.push_back(7'h00);
        press(4'h1);
        tick(5);
        press(4'h2);
        tick(3);
        cfg_i.trig_mode <= cts_pkg::CTS_TRIG_MANUAL;
        play_mode_i <= 1'b1;
        exp_q.push_back(7'h40);
        exp_q.push_back(7'h00);
        camera_button_i <= 1'b1;
        tick(3);
        camera_button_i <= 1'b0;
        tick(3);
        play(7'h30);
        exp_q.push_back(7'h10);
        tick(25);
        exp_q.push_back(7'h50);
        exp_q.push_back(7'h10);
        camera_button_i <= 1'b1;
        tick(4);
        camera_button_i <= 1'b0;
        tick(3);
        exp_q.push_back(7'h00);
        press(4'h2);
        tick(5);
        cfg_i.trig_mode <= cts_pkg::CTS_TRIG_INTERVAL;
        cfg_i.sync_source_select <= cts_pkg::CTS_SYNC_VIDEO;
        play(7'h10);
        repeat (3)
        begin
            exp_q.push_back(7'h70);
            exp_q.push_back(7'h10);
            tick(8);
            press(4'h8);
        end
        tick(8);
        exp_q.push_back(7'h00);
        press(4'h2);
        tick(5);
        // A zero timeout gives up at once, so no sync source is needed here.
        cfg_i.trig_mode <= cts_pkg::CTS_TRIG_MANUAL;
        cfg_i.sync_source_select <= cts_pkg::CTS_SYNC_GENERAL;
        cfg_i.sync_timeout_sec <= 8'h00;
        play(7'h04);
        tick(10);
        check("pending", exp_q.size(), 0);
        give_verdict();
    end
endmodule : cts_sequencer_tb_top
